// ### hw/bstap_controller.sv
// Boundary scan test access port controller with its instruction and data registers.
`timescale 1ns/1ps
module bstap_controller #(
   parameter logic [bstap_pkg::ID_LEN-1:0] ID_CODE = bstap_pkg::ID_CODE_DEFAULT
) (
   // Reference clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Test port link
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdoOut,
   output logic tdoOe,
   // Functional pin side
   input wire logic [bstap_pkg::BSR_LEN-1:0] pinIn,
   output logic [bstap_pkg::BSR_LEN-1:0] pinDrive,
   output logic pinTestMode,
   output logic [bstap_pkg::IR_LEN-1:0] currentInstr
);

   bstap_pkg::bstap_rise_t rise_reg;
   bstap_pkg::bstap_rise_t rise_next;
   bstap_pkg::bstap_fall_t fall_reg;
   bstap_pkg::bstap_fall_t fall_next;
   bstap_pkg::bstap_ref_t ref_reg;
   bstap_pkg::bstap_ref_t ref_next;

   logic selBsr;
   logic selId;

   // The test clock may stand still, so the reset reaches the test domain
   // asynchronously from a registered copy of the system reset.
   logic tapRst;
   assign tapRst = ref_reg.tapRst;

   assign selBsr = (fall_reg.instr == bstap_pkg::INSTR_EXTEST) || (fall_reg.instr == bstap_pkg::INSTR_SAMPLE);
   assign selId = (fall_reg.instr == bstap_pkg::INSTR_IDCODE);

   // Rising edge: state walk and shift registers.
   always_comb begin
      rise_next = rise_reg;
      rise_next.pinMeta = pinIn;
      rise_next.pinSync = rise_reg.pinMeta;
      case (rise_reg.state)
         bstap_pkg::ST_RESET: begin
            rise_next.state = tms ? bstap_pkg::ST_RESET : bstap_pkg::ST_IDLE;
         end
         bstap_pkg::ST_IDLE: begin
            // Nothing is loaded here, so every register except the state and the pin synchroniser holds.
            rise_next.state = tms ? bstap_pkg::ST_SELECT_DR : bstap_pkg::ST_IDLE;
         end
         bstap_pkg::ST_SELECT_DR: begin
            rise_next.state = tms ? bstap_pkg::ST_SELECT_IR : bstap_pkg::ST_CAPTURE_DR;
         end
         bstap_pkg::ST_CAPTURE_DR: begin
            if (selBsr) begin
               rise_next.bsrShift = rise_reg.pinSync;
            end else if (selId) begin
               rise_next.idShift = ID_CODE;
            end else begin
               rise_next.bypassBit = 1'h0;
            end
            rise_next.state = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
         end
         bstap_pkg::ST_SHIFT_DR: begin
            if (selBsr) begin
               rise_next.bsrShift = {tdi, rise_reg.bsrShift[bstap_pkg::BSR_LEN-1:1]};
            end else if (selId) begin
               rise_next.idShift = {tdi, rise_reg.idShift[bstap_pkg::ID_LEN-1:1]};
            end else begin
               rise_next.bypassBit = tdi;
            end
            rise_next.state = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
         end
         bstap_pkg::ST_EXIT1_DR: begin
            rise_next.state = tms ? bstap_pkg::ST_UPDATE_DR : bstap_pkg::ST_PAUSE_DR;
         end
         bstap_pkg::ST_PAUSE_DR: begin
            rise_next.state = tms ? bstap_pkg::ST_EXIT2_DR : bstap_pkg::ST_PAUSE_DR;
         end
         bstap_pkg::ST_EXIT2_DR: begin
            rise_next.state = tms ? bstap_pkg::ST_UPDATE_DR : bstap_pkg::ST_SHIFT_DR;
         end
         bstap_pkg::ST_UPDATE_DR: begin
            rise_next.state = tms ? bstap_pkg::ST_SELECT_DR : bstap_pkg::ST_IDLE;
         end
         bstap_pkg::ST_SELECT_IR: begin
            rise_next.state = tms ? bstap_pkg::ST_RESET : bstap_pkg::ST_CAPTURE_IR;
         end
         bstap_pkg::ST_CAPTURE_IR: begin
            rise_next.irShift = bstap_pkg::IR_CAPTURE_PATTERN;
            rise_next.state = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
         end
         bstap_pkg::ST_SHIFT_IR: begin
            // Least significant bit leaves first, new bits enter at the top.
            rise_next.irShift = {tdi, rise_reg.irShift[bstap_pkg::IR_LEN-1:1]};
            rise_next.state = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
         end
         bstap_pkg::ST_EXIT1_IR: begin
            rise_next.state = tms ? bstap_pkg::ST_UPDATE_IR : bstap_pkg::ST_PAUSE_IR;
         end
         bstap_pkg::ST_PAUSE_IR: begin
            rise_next.state = tms ? bstap_pkg::ST_EXIT2_IR : bstap_pkg::ST_PAUSE_IR;
         end
         bstap_pkg::ST_EXIT2_IR: begin
            rise_next.state = tms ? bstap_pkg::ST_UPDATE_IR : bstap_pkg::ST_SHIFT_IR;
         end
         bstap_pkg::ST_UPDATE_IR: begin
            rise_next.state = tms ? bstap_pkg::ST_SELECT_DR : bstap_pkg::ST_IDLE;
         end
         default: begin
            rise_next.state = bstap_pkg::ST_RESET;
         end
      endcase
   end

   always_ff @(posedge tck or posedge tapRst) begin
      if (tapRst) begin
         rise_reg.state <= bstap_pkg::ST_RESET;
         rise_reg.irShift <= bstap_pkg::IR_CAPTURE_PATTERN;
         rise_reg.bsrShift <= '0;
         rise_reg.idShift <= '0;
         rise_reg.bypassBit <= 1'h0;
         rise_reg.pinMeta <= '0;
         rise_reg.pinSync <= '0;
      end else begin
         rise_reg <= rise_next;
      end
   end

   // Falling edge: update latches and the serial output, so the tester sees a
   // settled bit at its next rising edge.
   always_comb begin
      fall_next = fall_reg;
      fall_next.tdoEn = 1'h0;
      fall_next.tdo = 1'h0;
      case (rise_reg.state)
         bstap_pkg::ST_RESET: begin
            fall_next.instr = bstap_pkg::INSTR_IDCODE;
            // A forced return to identification must reach the reference copy as well,
            // otherwise the pins would stay in test mode after a reset through the mode line.
            if (fall_reg.instr != bstap_pkg::INSTR_IDCODE) begin
               fall_next.updToggle = ~fall_reg.updToggle;
            end
         end
         bstap_pkg::ST_UPDATE_IR: begin
            fall_next.instr = rise_reg.irShift;
            fall_next.updToggle = ~fall_reg.updToggle;
         end
         bstap_pkg::ST_UPDATE_DR: begin
            if (selBsr) begin
               fall_next.bsrLatch = rise_reg.bsrShift;
               fall_next.updToggle = ~fall_reg.updToggle;
            end
         end
         bstap_pkg::ST_SHIFT_IR: begin
            fall_next.tdoEn = 1'h1;
            fall_next.tdo = rise_reg.irShift[0];
         end
         bstap_pkg::ST_SHIFT_DR: begin
            fall_next.tdoEn = 1'h1;
            if (selBsr) begin
               fall_next.tdo = rise_reg.bsrShift[0];
            end else if (selId) begin
               fall_next.tdo = rise_reg.idShift[0];
            end else begin
               fall_next.tdo = rise_reg.bypassBit;
            end
         end
         default: begin
            fall_next.tdoEn = 1'h0;
         end
      endcase
   end

   always_ff @(negedge tck or posedge tapRst) begin
      if (tapRst) begin
         fall_reg.instr <= bstap_pkg::INSTR_IDCODE;
         fall_reg.bsrLatch <= '0;
         fall_reg.tdo <= 1'h0;
         fall_reg.tdoEn <= 1'h0;
         fall_reg.updToggle <= 1'h0;
      end else begin
         fall_reg <= fall_next;
      end
   end

   // Reference domain: an update toggles a flag; the latched words are stable
   // until the next update, so they are copied once the toggle has synchronised.
   always_comb begin
      ref_next = ref_reg;
      ref_next.tapRst = 1'h0;
      ref_next.togMeta = fall_reg.updToggle;
      ref_next.togSync = ref_reg.togMeta;
      ref_next.togSeen = ref_reg.togSync;
      if (ref_reg.togSync != ref_reg.togSeen) begin
         ref_next.instrOut = fall_reg.instr;
         ref_next.pinOut = fall_reg.bsrLatch;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ref_reg.tapRst <= 1'h1;
         ref_reg.togMeta <= 1'h0;
         ref_reg.togSync <= 1'h0;
         ref_reg.togSeen <= 1'h0;
         ref_reg.instrOut <= bstap_pkg::INSTR_IDCODE;
         ref_reg.pinOut <= '0;
      end else begin
         ref_reg <= ref_next;
      end
   end

   assign tdoOut = fall_reg.tdo;
   assign tdoOe = fall_reg.tdoEn;
   assign pinDrive = ref_reg.pinOut;
   // Only EXTEST takes the pins away from normal operation.
   assign pinTestMode = (ref_reg.instrOut == bstap_pkg::INSTR_EXTEST);
   assign currentInstr = ref_reg.instrOut;

endmodule : bstap_controller

// ### hw/bstap_pkg.sv
// Constants and types for the boundary scan test access port controller.
// Function
// - Reset state disables test logic and makes identification the current instruction.
// - Five or more rising edges with TMS high reach reset; stays while high.
// - Power-up enters the reset state without any test clock edges.
// - Idle holds while TMS low, goes to data select when TMS high.
// - Idle leaves instruction and all data registers unchanged.
// - Data select: TMS low to data capture, TMS high to instruction select.
// - Data capture samples pins only for EXTEST or SAMPLE; next Exit1 or Shift.
// - Shift-DR moves selected register one stage toward TDO per rising edge.
// - Exit1-DR: TMS high to Update-DR, low to Pause-DR; nothing changes.
// - Pause-DR holds contents while TMS low, goes to Exit2-DR on high.
// - Exit2-DR: TMS high to Update-DR, low back to Shift-DR; contents held.
// - Boundary output latch updates on falling edge in Update-DR only.
// - Instruction select: TMS low to Capture-IR, high back to reset.
// - Capture-IR loads pattern 100 into instruction shifter; next Exit1 or Shift.
// - Shift-IR moves instruction shifter one stage toward TDO per rising edge.
// - Exit1-IR: TMS high to Update-IR, low to Pause-IR; nothing changes.
// - Instruction register is three bits, shifted in least significant bit first.
// - Decode 000 EXTEST, 100 SAMPLE, 110 IDCODE, 111 BYPASS; bypass delays one period.
// - Pause-IR holds while TMS low; Exit2-IR goes to Update-IR or Shift-IR.
// - Update-IR latches shifted instruction on falling edge as current instruction.
package bstap_pkg;

   localparam int IR_LEN = 3;
   localparam int BSR_LEN = 98;
   localparam int ID_LEN = 32;
   localparam int TLR_TMS_EDGES = 5;

   localparam logic [IR_LEN-1:0] IR_CAPTURE_PATTERN = 3'h4;
   localparam logic [IR_LEN-1:0] INSTR_EXTEST = 3'h0;
   localparam logic [IR_LEN-1:0] INSTR_SAMPLE = 3'h4;
   localparam logic [IR_LEN-1:0] INSTR_IDCODE = 3'h6;
   localparam logic [IR_LEN-1:0] INSTR_BYPASS = 3'h7;

   // Arbitrary identification value; bit 0 must stay set.
   localparam logic [ID_LEN-1:0] ID_CODE_DEFAULT = 32'h0ABC_D001;

   typedef enum logic [3:0] {
      ST_EXIT2_DR = 4'h0,
      ST_EXIT1_DR = 4'h1,
      ST_SHIFT_DR = 4'h2,
      ST_PAUSE_DR = 4'h3,
      ST_SELECT_IR = 4'h4,
      ST_UPDATE_DR = 4'h5,
      ST_CAPTURE_DR = 4'h6,
      ST_SELECT_DR = 4'h7,
      ST_EXIT2_IR = 4'h8,
      ST_EXIT1_IR = 4'h9,
      ST_SHIFT_IR = 4'hA,
      ST_PAUSE_IR = 4'hB,
      ST_IDLE = 4'hC,
      ST_UPDATE_IR = 4'hD,
      ST_CAPTURE_IR = 4'hE,
      ST_RESET = 4'hF
   } bstap_state_t;

   // Rising-edge test clock state.
   typedef struct packed {
      bstap_state_t state;
      logic [IR_LEN-1:0] irShift;
      logic [BSR_LEN-1:0] bsrShift;
      logic [ID_LEN-1:0] idShift;
      logic bypassBit;
      logic [BSR_LEN-1:0] pinMeta;
      logic [BSR_LEN-1:0] pinSync;
   } bstap_rise_t;

   // Falling-edge test clock state.
   typedef struct packed {
      logic [IR_LEN-1:0] instr;
      logic [BSR_LEN-1:0] bsrLatch;
      logic tdo;
      logic tdoEn;
      logic updToggle;
   } bstap_fall_t;

   // Reference clock state.
   typedef struct packed {
      logic tapRst;
      logic togMeta;
      logic togSync;
      logic togSeen;
      logic [IR_LEN-1:0] instrOut;
      logic [BSR_LEN-1:0] pinOut;
   } bstap_ref_t;

endpackage : bstap_pkg

// ### testbench/bstap_controller_assertions.sv
// Port-level assertions for the boundary scan controller.
`timescale 1ns/1ps
module bstap_checker #(
   parameter logic [bstap_pkg::ID_LEN-1:0] ID_CODE = bstap_pkg::ID_CODE_DEFAULT
) (
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic tck,
   // Watched signals
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdoOut,
   input wire logic tdoOe,
   input wire logic pinTestMode,
   input wire logic [bstap_pkg::IR_LEN-1:0] currentInstr
);
   localparam logic [63:0] NEXT_LOW = 64'hCACC_BABA_62CE_3232;
   localparam logic [63:0] NEXT_HIGH = 64'hF977_89DD_417F_0155;
   logic [3:0] st;
   // A private copy of the state walk, kept only to qualify the checks.
   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         st <= 4'hF;
      end else begin
         st <= tms ? NEXT_HIGH[st*4 +: 4] : NEXT_LOW[st*4 +: 4];
      end
   end
   property p_oe_shift;
      @(posedge tck) disable iff (rst) tdoOe == (st == 4'h2 || st == 4'hA);
   endproperty
   a_oe_shift: assert property (p_oe_shift) else $error("output enable outside shift states");
   property p_tdo_idle;
      @(posedge tck) disable iff (rst) !tdoOe |-> !tdoOut;
   endproperty
   a_tdo_idle: assert property (p_tdo_idle) else $error("serial output not low while idle");
   property p_ir_capture;
      @(posedge tck) disable iff (rst) (st == 4'hE && !tms) |=> tdoOe && !tdoOut;
   endproperty
   a_ir_capture: assert property (p_ir_capture) else $error("wrong first captured instruction bit");
   property p_bypass;
      @(posedge tck) disable iff (rst)
         (st == 4'h2 && $past(st) == 4'h2 && currentInstr == bstap_pkg::INSTR_BYPASS) |-> tdoOut == $past(tdi);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass delay is not one period");
   property p_id_first;
      @(posedge tck) disable iff (rst)
         (st == 4'h6 && !tms && currentInstr == bstap_pkg::INSTR_IDCODE) |=> tdoOut == ID_CODE[0];
   endproperty
   a_id_first: assert property (p_id_first) else $error("identification low bit wrong");
   property p_tlr;
      @(posedge tck) disable iff (rst) tms [*5] |=> !tdoOe;
   endproperty
   a_tlr: assert property (p_tlr) else $error("five high mode edges did not stop shifting");
   property p_rst_instr;
      @(posedge ref_clk) rst |=> currentInstr == bstap_pkg::INSTR_IDCODE && !pinTestMode;
   endproperty
   a_rst_instr: assert property (p_rst_instr) else $error("reset did not select identification");
   property p_test_mode;
      @(posedge ref_clk) disable iff (rst) pinTestMode == (currentInstr == bstap_pkg::INSTR_EXTEST);
   endproperty
   a_test_mode: assert property (p_test_mode) else $error("pin test mode disagrees with instruction");
   c_bypass: cover property (@(posedge tck) st == 4'h2 && currentInstr == bstap_pkg::INSTR_BYPASS);
   c_pause_ir: cover property (@(posedge tck) st == 4'hB);
   c_extest: cover property (@(posedge ref_clk) pinTestMode);
endmodule : bstap_checker

bind bstap_controller bstap_checker #(.ID_CODE(ID_CODE)) i_checker (.ref_clk(ref_clk), .rst(rst), .tck(tck),
   .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .pinTestMode(pinTestMode), .currentInstr(currentInstr));

// ### testbench/bstap_tester.sv
// Behavioural board tester that clocks and drives the test port.
`timescale 1ns/1ps
module bstap_tester (
   // Test port link
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdoOut,
   input wire logic tdoOe
);
   int slowNs = 0;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // The clock rests low between calls, so it never runs outside frames.
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #(6 + slowNs);
      tck = 1'b1;
      o = tdoOe ? tdoOut : 1'bz;
      #6;
      tck = 1'b0;
   endtask : step
   task automatic scan(input logic ir, input logic [127:0] din, input int n, input int pauseAt,
                       output logic [127:0] dout);
      logic o;
      dout = '0;
      step(1'b1, 1'b0, o);
      if (ir) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1 || i == pauseAt, din[i], dout[i]);
         if (i == pauseAt && i < n - 1) begin
            step(1'b0, 1'b0, o);
            step(1'b0, 1'b0, o);
            step(1'b1, 1'b0, o);
            step(1'b0, 1'b0, o);
         end
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask : scan
endmodule : bstap_tester

// ### testbench/tb_top.sv
// Self-checking bench for the boundary scan controller.
`timescale 1ns/1ps
module tb_top;
   logic ref_clk;
   logic rst;
   logic tck, tms, tdi, tdoOut, tdoOe, pinTestMode;
   logic [bstap_pkg::BSR_LEN-1:0] pinIn;
   logic [bstap_pkg::BSR_LEN-1:0] pinDrive;
   logic [bstap_pkg::IR_LEN-1:0] currentInstr;
   logic [127:0] got, dat, sh, exp, latchModel;
   logic [2:0] codes[$] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h1};
   int n;
   int mismatches = 0;
   int samplesChecked = 0;
   bstap_controller i_dut (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut),
      .tdoOe(tdoOe), .pinIn(pinIn), .pinDrive(pinDrive), .pinTestMode(pinTestMode), .currentInstr(currentInstr));
   bstap_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [127:0] g, input logic [127:0] e);
      samplesChecked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %0h, expected %0h", $time, g, e);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   task automatic loadIr(input logic [2:0] code, input int pauseAt);
      i_tester.scan(1'b1, {125'h0, code}, 3, pauseAt, got);
      check(got, 128'h4);
      repeat (6) @(posedge ref_clk);
      check(currentInstr, code);
   endtask : loadIr
   initial begin
      repeat (100000) @(posedge ref_clk);
      mismatches++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'hCBDE));
      rst = 1'b1;
      pinIn = '0;
      latchModel = '0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check(currentInstr, bstap_pkg::INSTR_IDCODE);
      #3;
      i_tester.step(1'b0, 1'b0, got[0]);
      i_tester.scan(1'b0, '0, 32, 7, got);
      check(got, bstap_pkg::ID_CODE_DEFAULT);
      foreach (codes[k]) begin
         i_tester.slowNs = $urandom_range(0, 20);
         loadIr(codes[k], k);
         dat = {$urandom, $urandom, $urandom, $urandom};
         sh = ~dat;
         @(posedge ref_clk);
         pinIn <= dat[97:0];
         repeat (2) @(posedge ref_clk);
         case (codes[k])
            3'h0, 3'h4: begin
               n = 98;
               exp = dat[97:0];
               latchModel = sh[97:0];
            end
            3'h6: begin
               n = 32;
               exp = bstap_pkg::ID_CODE_DEFAULT;
            end
            default: begin
               n = 16;
               exp = {sh[14:0], 1'b0};
            end
         endcase
         i_tester.scan(1'b0, sh, n, 40, got);
         check(got, exp);
         repeat (6) @(posedge ref_clk);
         check(pinDrive, latchModel);
         check(pinTestMode, codes[k] == 3'h0);
      end
      loadIr(3'h0, 9);
      i_tester.scan(1'b0, '0, 0, 9, got);
      repeat (5) i_tester.step(1'b1, 1'b0, got[0]);
      repeat (6) @(posedge ref_clk);
      check(currentInstr, bstap_pkg::INSTR_IDCODE);
      check(pinTestMode, 1'b0);
      i_tester.step(1'b0, 1'b0, got[0]);
      i_tester.scan(1'b0, '0, 32, 40, got);
      check(got, bstap_pkg::ID_CODE_DEFAULT);
      end_of_test;
   end
endmodule : tb_top
